/* File: include/fp_round_classify_consts.svh */
// Offsets, field positions, reset values and format limits of the
// floating front end. Assumes byte addresses on a 32-bit Wishbone bus.
`ifndef FP_ROUND_CLASSIFY_CONSTS_SVH
`define FP_ROUND_CLASSIFY_CONSTS_SVH

// ************************************************
// Register byte offsets
// ************************************************
`define OFS_CTRL 8'h00
`define OFS_INSN 8'h04
`define OFS_STATUS 8'h08
`define OFS_OPND_LO 8'h0C
`define OFS_OPND_HI 8'h10
`define OFS_CLASS 8'h14
`define OFS_RND_CTRL 8'h18
`define OFS_MANT_LO 8'h1C
`define OFS_MANT_HI 8'h20
`define OFS_RES_LO 8'h24
`define OFS_RES_HI 8'h28
`define OFS_RND_STAT 8'h2C

// ************************************************
// Field positions
// ************************************************
`define CTRL_ENABLE_BIT 0
`define CTRL_DYN_LSB 1
`define RND_SIGN_BIT 0
`define RND_EXP_LSB 1
`define RND_GUARD_BIT 14
`define RND_STICKY_BIT 15
`define RND_ZERO_BIT 16

// ************************************************
// Reset values and format limits
// ************************************************
`define CTRL_RESET 32'h0000_0004
`define EMAX_LEG_SINGLE 13'h00FF
`define EMAX_IEEE_SINGLE 13'h00FE
`define EMAX_LEG_DOUBLE 13'h07FF
`define EMAX_IEEE_DOUBLE 13'h07FE
`define EMIN_ALL 13'h0001

`endif

/* File: include/fp_round_classify_pkg.sv */
// Types shared by the floating front end and its classifier.
// Assumes the constants header is included by the design files.
package fp_round_classify_pkg;

   // ************************************************
   // Formats, qualifiers and modes
   // ************************************************
   typedef enum logic [1:0] {FMT_LSINGLE, FMT_LDOUBLE, FMT_ISINGLE, FMT_IDOUBLE} fmt_t;
   typedef enum logic [1:0] {QUAL_NONE, QUAL_CHOP, QUAL_MINUS, QUAL_DYN} qual_t;
   typedef enum logic [1:0] {CLS_COMMON, CLS_LEGACY, CLS_IEEE, CLS_MEMORY} iclass_t;
   typedef enum logic [2:0] {RND_LNEAR, RND_NEAR, RND_CHOP, RND_MINUS, RND_PLUS} rnd_t;

   typedef struct packed {
      logic [3:0] mm_fault;
      iclass_t iclass;
      logic [1:0] trap_mode;
      qual_t qual;
      fmt_t fmt;
   } insn_t;

   typedef struct packed {
      logic sign;
      logic true_zero;
      logic finite;
      logic dirty_zero;
      logic reserved;
      logic denormal;
      logic infinity;
      logic snan;
      logic qnan;
   } class_t;

endpackage

/* File: hdl/fp_classify.sv */
// Operand classifier: splits a 64-bit operand by format and names it.
// Assumes single formats sit in the low word, double in the full word.
`timescale 1ns/1ns
`include "fp_round_classify_consts.svh"
module fp_classify (
   input wire logic [63:0] opnd,
   input wire fp_round_classify_pkg::fmt_t fmt,
   output fp_round_classify_pkg::class_t cls
);
   import fp_round_classify_pkg::*;

   // ************************************************
   // Field split
   // ************************************************
   wire dbl = (fmt == FMT_LDOUBLE) || (fmt == FMT_IDOUBLE);
   wire ieee = (fmt == FMT_ISINGLE) || (fmt == FMT_IDOUBLE);
   wire sign = dbl ? opnd[63] : opnd[31];
   wire [10:0] exp_f = dbl ? opnd[62:52] : {3'h0, opnd[30:23]};
   wire [51:0] frac = dbl ? opnd[51:0] : {opnd[22:0], 29'h0};
   wire exp_zero = (exp_f == 11'h000);
   wire exp_ones = dbl ? (exp_f == 11'h7FF) : (exp_f[7:0] == 8'hFF);
   wire frac_zero = (frac == 52'h0);

   // ************************************************
   // Classification
   // ************************************************
   wire l_dirty = !ieee && exp_zero && !sign && !frac_zero;
   wire l_resv = !ieee && exp_zero && sign;
   wire i_inf = ieee && exp_ones && frac_zero;
   wire i_nan = ieee && exp_ones && !frac_zero;
   wire i_den = ieee && exp_zero && !frac_zero;

   assign cls.sign = sign;
   assign cls.true_zero = exp_zero && frac_zero && !sign;
   assign cls.finite = !(l_dirty || l_resv || i_inf || i_nan || i_den);
   assign cls.dirty_zero = l_dirty;
   assign cls.reserved = l_resv;
   assign cls.denormal = i_den;
   assign cls.infinity = i_inf;
   assign cls.snan = i_nan && frac[51];
   assign cls.qnan = i_nan && !frac[51];
endmodule

/* File: hdl/fp_round_classify.sv */
// Floating front end: permission check, operand classify and rounding.
// Assumes a classic Wishbone master on clk_sys and decode logic that
// writes each instruction word to the INSN register.
//
// Operation
// - Format, rounding, trap mode come from instruction
// - Legacy zero results become the true zero
// - Enable clear: implemented instruction takes disabled fault
// - Unimplemented gives illegal trap, beats disabled fault
// - Either subset present implies common instructions
// - Omitted directed rounding gives illegal trap
// - Loads and stores report memory management faults
// - True zero is all 64 bits clear for double, the low 32 for single
// - Decode sign, exponent and fraction per format
// - NaN leading fraction one signals, zero quiet
// - Legacy dirty zero, reserved operand non-finite
// - IEEE infinity, NaN, denormal are non-finite
// - Exact results pass unchanged in every mode
// - Legacy nearest, ties away, half-LSB limits
// - Legacy chop truncates, one-LSB overflow limit
// - IEEE nearest, ties to even, half-LSB limits
// - Plus infinity takes larger neighbour
// - Minus infinity takes smaller neighbour
// - IEEE chop truncates toward smaller magnitude
// - IEEE rounds first, then tests range
// - Dynamic qualifier uses control register field
// - Plus infinity only via dynamic field 11
`timescale 1ns/1ns
`include "fp_round_classify_consts.svh"
module fp_round_classify #(
   parameter bit HAS_LEGACY = 1'b1,
   parameter bit HAS_IEEE = 1'b1,
   parameter bit HAS_DIRECTED = 1'b1
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic fp_disabled_fault,
   output logic illegal_instr_trap,
   output logic [3:0] mm_fault
);
   import fp_round_classify_pkg::*;

   // ************************************************
   // Helpers
   // ************************************************
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Increment decision of the rounder
   function automatic logic round_up(input rnd_t m, input logic sign, input logic lsb,
                                     input logic g, input logic s);
      logic r;
      r = 1'b0;
      case (m)
         RND_LNEAR: r = g;
         RND_NEAR: r = g && (s || lsb);
         RND_PLUS: r = (g || s) && !sign;
         RND_MINUS: r = (g || s) && sign;
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   // ************************************************
   // Registers
   // ************************************************
   logic [31:0] ctrl_q, ctrl_d;
   insn_t insn_q, insn_d;
   logic [31:0] opnd_lo_q, opnd_lo_d, opnd_hi_q, opnd_hi_d;
   logic [16:0] rnd_ctrl_q, rnd_ctrl_d;
   logic [31:0] mant_lo_q, mant_lo_d;
   logic [20:0] mant_hi_q, mant_hi_d;
   logic [63:0] res_q, res_d;
   logic [3:0] rstat_q, rstat_d;
   rnd_t mode_q, mode_d;
   logic ok_q, ok_d;
   logic dis_d, ill_d;
   logic [3:0] mmf_d;
   logic ack_d;
   logic [31:0] dat_d;

   // ************************************************
   // Bus decode
   // ************************************************
   wire req = wb_cyc_i && wb_stb_i;
   // Writes land on the ack edge, while the master still holds its data
   wire wr = req && wb_we_i && wb_ack_o;
   wire [7:0] adr = {wb_adr_i[7:2], 2'b00};
   wire hit_ctrl = (adr == `OFS_CTRL);
   wire hit_insn = (adr == `OFS_INSN);
   wire hit_status = (adr == `OFS_STATUS);
   wire hit_olo = (adr == `OFS_OPND_LO);
   wire hit_ohi = (adr == `OFS_OPND_HI);
   wire hit_class = (adr == `OFS_CLASS);
   wire hit_rctl = (adr == `OFS_RND_CTRL);
   wire hit_mlo = (adr == `OFS_MANT_LO);
   wire hit_mhi = (adr == `OFS_MANT_HI);
   wire hit_rlo = (adr == `OFS_RES_LO);
   wire hit_rhi = (adr == `OFS_RES_HI);
   wire hit_rst = (adr == `OFS_RND_STAT);

   // ************************************************
   // Permission check on a written instruction
   // ************************************************
   // Decode is taken straight from the new word, so the check and the
   // latched format and mode always belong to the same instruction
   wire [31:0] insn_w = merge(32'({insn_q}), wb_dat_i, wb_sel_i);
   insn_t ni;
   assign ni = insn_t'(insn_w[11:0]);
   wire n_legfmt = (ni.fmt == FMT_LSINGLE) || (ni.fmt == FMT_LDOUBLE);
   wire fmt_impl = n_legfmt ? HAS_LEGACY : HAS_IEEE;
   wire [1:0] dynamic_round_field = ctrl_q[`CTRL_DYN_LSB +: 2];
   wire [3:0] dyn_class = 4'(1) << dynamic_round_field;
   wire rnd_t_dyn_plus = dyn_class[3];
   rnd_t dyn_mode;
   assign dyn_mode = rnd_t_dyn_plus ? RND_PLUS :
                     dyn_class[2] ? RND_NEAR :
                     dyn_class[1] ? RND_MINUS : RND_CHOP;
   rnd_t new_mode;
   assign new_mode = n_legfmt ? ((ni.qual == QUAL_CHOP) ? RND_CHOP : RND_LNEAR) :
                     (ni.qual == QUAL_NONE) ? RND_NEAR :
                     (ni.qual == QUAL_CHOP) ? RND_CHOP :
                     (ni.qual == QUAL_MINUS) ? RND_MINUS : dyn_mode;
   // Legacy formats know only the none and chop qualifiers
   wire qual_bad = n_legfmt && (ni.qual != QUAL_NONE) && (ni.qual != QUAL_CHOP);
   wire class_impl = (ni.iclass == CLS_LEGACY) ? HAS_LEGACY :
                     (ni.iclass == CLS_IEEE) ? HAS_IEEE :
                     (HAS_LEGACY || HAS_IEEE);
   wire dir_bad = !HAS_DIRECTED && ((new_mode == RND_PLUS) || (new_mode == RND_MINUS));
   wire n_illegal = !class_impl || !fmt_impl || qual_bad || dir_bad;
   wire n_disabled = !n_illegal && !ctrl_q[`CTRL_ENABLE_BIT];
   wire n_mem = (ni.iclass == CLS_MEMORY);

   // ************************************************
   // Classifier
   // ************************************************
   class_t cls;
   fp_classify u_classify (
      .opnd({opnd_hi_q, opnd_lo_q}),
      .fmt(insn_q.fmt),
      .cls(cls)
   );

   // ************************************************
   // Rounder
   // ************************************************
   // Caller supplies a normalised significand with its leading bit,
   // right aligned: 24 bits for single, 53 for double
   wire dbl = (insn_q.fmt == FMT_LDOUBLE) || (insn_q.fmt == FMT_IDOUBLE);
   wire legacy = (insn_q.fmt == FMT_LSINGLE) || (insn_q.fmt == FMT_LDOUBLE);
   wire [16:0] rc_w = 17'(merge(32'(rnd_ctrl_q), wb_dat_i, wb_sel_i));
   wire [52:0] mant = {mant_hi_q, mant_lo_q};
   wire r_sign = rc_w[`RND_SIGN_BIT];
   wire signed [12:0] r_exp = rc_w[`RND_EXP_LSB +: 13];
   wire r_g = rc_w[`RND_GUARD_BIT];
   wire r_s = rc_w[`RND_STICKY_BIT];
   wire r_zero = rc_w[`RND_ZERO_BIT];
   // No guard and no sticky means the value is exact: no increment
   wire inc = (r_g || r_s) && round_up(mode_q, r_sign, mant[0], r_g, r_s);
   wire [53:0] sum = {1'b0, mant} + {53'h0, inc};
   wire carry = dbl ? sum[53] : sum[24];
   wire [51:0] frac_r = carry ? sum[52:1] : sum[51:0];
   wire signed [12:0] exp_r = r_exp + {12'h000, carry};
   wire [12:0] emax = dbl ? (legacy ? `EMAX_LEG_DOUBLE : `EMAX_IEEE_DOUBLE) :
                            (legacy ? `EMAX_LEG_SINGLE : `EMAX_IEEE_SINGLE);
   // Range tested on the rounded exponent, never the raw one
   wire ovf = !r_zero && (exp_r > $signed(emax));
   wire unf = !r_zero && (exp_r < $signed(`EMIN_ALL));
   wire [63:0] packed_r = dbl ? {r_sign, exp_r[10:0], frac_r} :
                                {32'h0, r_sign, exp_r[7:0], frac_r[22:0]};
   // Zero and underflow both give the true zero, even where -0 was due
   wire [63:0] res_n = (r_zero || unf || ovf) ? 64'h0 : packed_r;
   wire inexact = !r_zero && (r_g || r_s);

   // ************************************************
   // Next state
   // ************************************************
   always_comb begin
      ctrl_d = ctrl_q;
      insn_d = insn_q;
      opnd_lo_d = opnd_lo_q;
      opnd_hi_d = opnd_hi_q;
      rnd_ctrl_d = rnd_ctrl_q;
      mant_lo_d = mant_lo_q;
      mant_hi_d = mant_hi_q;
      res_d = res_q;
      rstat_d = rstat_q;
      mode_d = mode_q;
      ok_d = ok_q;
      dis_d = fp_disabled_fault;
      ill_d = illegal_instr_trap;
      mmf_d = mm_fault;
      if (wr && hit_ctrl) begin
         ctrl_d = merge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_0007;
      end else if (wr && hit_insn) begin
         insn_d = ni;
         mode_d = new_mode;
         ill_d = n_illegal;
         dis_d = n_disabled;
         ok_d = !n_illegal && !n_disabled;
         mmf_d = (n_mem && !n_illegal && !n_disabled) ? ni.mm_fault : 4'h0;
      end else if (wr && hit_olo) begin
         opnd_lo_d = merge(opnd_lo_q, wb_dat_i, wb_sel_i);
      end else if (wr && hit_ohi) begin
         opnd_hi_d = merge(opnd_hi_q, wb_dat_i, wb_sel_i);
      end else if (wr && hit_mlo) begin
         mant_lo_d = merge(mant_lo_q, wb_dat_i, wb_sel_i);
      end else if (wr && hit_mhi) begin
         mant_hi_d = 21'(merge(32'(mant_hi_q), wb_dat_i, wb_sel_i));
      end else if (wr && hit_rctl) begin
         // Rounding runs only for an accepted instruction
         rnd_ctrl_d = rc_w;
         if (ok_q) begin
            res_d = res_n;
            rstat_d = {1'b1, inexact, unf, ovf};
         end else begin
            res_d = 64'h0;
            rstat_d = 4'h0;
         end
      end
   end

   // ************************************************
   // Read data and acknowledge
   // ************************************************
   wire [31:0] status_w = {14'h0, 3'(mode_q), ok_q, mm_fault, insn_q.iclass,
                           insn_q.trap_mode, insn_q.qual, insn_q.fmt,
                           illegal_instr_trap, fp_disabled_fault};
   // Ack drops after one cycle even with strobe held high
   assign ack_d = req && !wb_ack_o;
   assign dat_d = !ack_d ? 32'h0 :
                  hit_ctrl ? ctrl_q :
                  hit_insn ? {20'h0, insn_q} :
                  hit_status ? status_w :
                  hit_olo ? opnd_lo_q :
                  hit_ohi ? opnd_hi_q :
                  hit_class ? {23'h0, cls} :
                  hit_rctl ? {15'h0, rnd_ctrl_q} :
                  hit_mlo ? mant_lo_q :
                  hit_mhi ? {11'h0, mant_hi_q} :
                  hit_rlo ? res_q[31:0] :
                  hit_rhi ? res_q[63:32] :
                  hit_rst ? {28'h0, rstat_q} : 32'h0;

   // ************************************************
   // Bus flip-flops
   // ************************************************
   // Ack and read data leave together and stand one cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= ack_d;
         wb_dat_o <= dat_d;
      end
   end

   // ************************************************
   // State flip-flops
   // ************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl_q <= `CTRL_RESET;
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // Latched instruction and the mode decoded with it
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         insn_q <= insn_t'(12'h000);
         mode_q <= RND_LNEAR;
         ok_q <= 1'b0;
      end else begin
         insn_q <= insn_d;
         mode_q <= mode_d;
         ok_q <= ok_d;
      end
   end

   // Fault outputs hold until the next instruction word
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         fp_disabled_fault <= 1'b0;
         illegal_instr_trap <= 1'b0;
         mm_fault <= 4'h0;
      end else begin
         fp_disabled_fault <= dis_d;
         illegal_instr_trap <= ill_d;
         mm_fault <= mmf_d;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         opnd_lo_q <= 32'h0;
         opnd_hi_q <= 32'h0;
      end else begin
         opnd_lo_q <= opnd_lo_d;
         opnd_hi_q <= opnd_hi_d;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rnd_ctrl_q <= 17'h0;
         mant_lo_q <= 32'h0;
         mant_hi_q <= 21'h0;
      end else begin
         rnd_ctrl_q <= rnd_ctrl_d;
         mant_lo_q <= mant_lo_d;
         mant_hi_q <= mant_hi_d;
      end
   end

   // Results change only on a rounding request
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         res_q <= 64'h0;
         rstat_q <= 4'h0;
      end else begin
         res_q <= res_d;
         rstat_q <= rstat_d;
      end
   end
endmodule

/* File: bench/fp_round_classify_properties.sv */
// Port checker for the floating front end.
// Assumes it is bound into fp_round_classify with its default parameters.
`timescale 1ns/1ns
module fp_round_classify_properties (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic fp_disabled_fault,
   input wire logic illegal_instr_trap,
   input wire logic [3:0] mm_fault
);
   logic en_q;
   wire wr_ack = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   wire insn_hit = wr_ack && (wb_adr_i[7:2] == 6'h01);
   // Legacy format with minus or dynamic qualifier
   wire leg_bad = !wb_dat_i[1] && wb_dat_i[3];
   wire req_new = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire [3:0] mm_bits = wb_dat_i[11:8];
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ************************************************
   // Enable shadow, the register itself is not visible here
   // ************************************************
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         en_q <= 1'b0;
      end else if (wr_ack && wb_adr_i[7:2] == 6'h00 && wb_sel_i[0]) begin
         en_q <= wb_dat_i[0];
      end
   end
   sequence common_insn(bit en);
      insn_hit && !leg_bad && wb_dat_i[7:6] == 2'h0 && en_q == en;
   endsequence
   // ************************************************
   // Properties
   // ************************************************
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held for more than one cycle");
   chk_ack_answer: assert property (1'b1 |=> wb_ack_o == $past(req_new))
      else $error("ack not one cycle after request");
   chk_read_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   chk_fault_excl: assert property (!(fp_disabled_fault && illegal_instr_trap))
      else $error("disabled and illegal raised together");
   chk_ill_legacy: assert property (insn_hit && leg_bad |=> illegal_instr_trap)
      else $error("legacy directed qualifier not illegal");
   chk_dis_fault: assert property (common_insn(1'b0) |=> fp_disabled_fault)
      else $error("disabled fault missing");
   chk_run_clean: assert property (common_insn(1'b1) |=> !fp_disabled_fault && !illegal_instr_trap)
      else $error("fault on implemented enabled instruction");
   chk_mm_report: assert property (insn_hit && en_q && wb_dat_i[7:6] == 2'h3 && !leg_bad
      |=> mm_fault == $past(mm_bits))
      else $error("memory fault bits not reported");
   chk_flag_hold: assert property (!insn_hit |=> $stable({fp_disabled_fault, illegal_instr_trap, mm_fault}))
      else $error("fault flags changed without instruction");
endmodule

bind fp_round_classify fp_round_classify_properties i_chk (.clk_sys(clk_sys), .rst(rst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .fp_disabled_fault(fp_disabled_fault), .illegal_instr_trap(illegal_instr_trap),
   .mm_fault(mm_fault));

/* File: bench/issue_model.sv */
// Decode and issue side model: a classic Wishbone master.
// Assumes the bench calls its tasks and owns the overall timeout.
`timescale 1ns/1ns
`include "fp_round_classify_consts.svh"
module issue_model (
   input wire logic clk_sys,
   output logic wb_cyc_o,
   output logic wb_stb_o,
   output logic wb_we_o,
   output logic [7:0] wb_adr_o,
   output logic [3:0] wb_sel_o,
   output logic [31:0] wb_dat_o,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_i
);
   import fp_round_classify_pkg::*;
   initial begin
      wb_cyc_o = 1'b0;
      wb_stb_o = 1'b0;
      wb_we_o = 1'b0;
      wb_adr_o = 8'h00;
      wb_sel_o = 4'hF;
      wb_dat_o = 32'h0;
   end
   // Waits as long as needed; only the bench timeout ends a hang
   task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd);
      @(posedge clk_sys);
      wb_cyc_o <= 1'b1;
      wb_stb_o <= 1'b1;
      wb_we_o <= we;
      wb_adr_o <= adr;
      wb_dat_o <= wd;
      @(posedge clk_sys);
      while (wb_ack_i !== 1'b1) @(posedge clk_sys);
      rd = wb_dat_i;
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      // Released lines show a changed value, never the old one
      wb_adr_o <= ~adr;
      wb_dat_o <= ~wd;
   endtask
   task automatic issue(input insn_t i);
      logic [31:0] rd;
      bus(1'b1, `OFS_INSN, {20'h0, i}, rd);
   endtask
   task automatic set_ctrl(input logic en, input logic [1:0] dynamic_round_field);
      logic [31:0] rd;
      bus(1'b1, `OFS_CTRL, {29'h0, dynamic_round_field, en}, rd);
   endtask
endmodule

/* File: bench/tb.sv */
// Self-checking bench for the floating front end.
// Assumes default design parameters and the issue model as bus master.
`timescale 1ns/1ns
`include "fp_round_classify_consts.svh"
module tb;
   import fp_round_classify_pkg::*;
   logic clk_sys, rst, cyc, stb, we, ack, dis, ill;
   logic [7:0] adr;
   logic [3:0] sel, mmf;
   logic [31:0] wdat, rdat, d;
   int fails, checks, cycles;
   fp_round_classify i_dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .fp_disabled_fault(dis), .illegal_instr_trap(ill), .mm_fault(mmf));
   issue_model i_issue (.clk_sys(clk_sys), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
      .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat), .wb_dat_i(rdat), .wb_ack_i(ack));
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // ************************************************
   // Shared tasks
   // ************************************************
   task automatic finish_test;
      if (fails == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fails++;
         finish_test();
      end
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a);
      i_issue.bus(1'b0, a, 32'h0, d);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      i_issue.bus(1'b1, a, v, d);
   endtask
   function automatic logic [16:0] rc(logic sg, logic [12:0] e, logic g, logic s, logic z);
      return {z, s, g, e, sg};
   endfunction
   task automatic flags(input insn_t i, input logic [5:0] exp);
      i_issue.issue(i);
      @(posedge clk_sys);
      check({58'h0, dis, ill, mmf}, {58'h0, exp});
   endtask
   task automatic cls(input fmt_t f, input logic [63:0] op, input logic [8:0] exp);
      wr(`OFS_OPND_LO, op[31:0]);
      wr(`OFS_OPND_HI, op[63:32]);
      i_issue.issue('{4'h0, CLS_COMMON, 2'h0, QUAL_NONE, f});
      rd(`OFS_CLASS);
      check({32'h0, d}, {55'h0, exp});
   endtask
   task automatic round(input fmt_t f, input qual_t q, input logic [1:0] dynamic_round_field,
         input logic [16:0] c, input logic [52:0] m, input logic [63:0] er, input logic [1:0] ef);
      logic [31:0] lo;
      int n;
      i_issue.set_ctrl(1'b1, dynamic_round_field);
      i_issue.issue('{4'h0, CLS_COMMON, 2'h1, q, f});
      wr(`OFS_MANT_LO, m[31:0]);
      wr(`OFS_MANT_HI, {11'h0, m[52:32]});
      wr(`OFS_RND_CTRL, {15'h0, c});
      n = 0;
      d = 32'h0;
      while (d[3] !== 1'b1 && n < 16) begin
         rd(`OFS_RND_STAT);
         n++;
      end
      check({61'h0, d[3], d[1:0]}, {61'h1, ef});
      rd(`OFS_RES_LO);
      lo = d;
      rd(`OFS_RES_HI);
      check({d, lo}, er);
   endtask
   // ************************************************
   // Main sequence
   // ************************************************
   initial begin
      rst = 1'b1;
      fails = 0;
      checks = 0;
      cycles = 0;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      rd(`OFS_CTRL);
      check({32'h0, d}, {32'h0, `CTRL_RESET});
      wr(`OFS_CTRL, 32'hFFFF_FFFF);
      rd(`OFS_CTRL);
      check({32'h0, d}, 64'h7);
      wr(8'h40, 32'hFFFF_FFFF);
      rd(8'h40);
      check({32'h0, d}, 64'h0);
      i_issue.set_ctrl(1'b0, 2'h2);
      flags('{4'h0, CLS_COMMON, 2'h0, QUAL_NONE, FMT_ISINGLE}, 6'h20);
      flags('{4'h0, CLS_COMMON, 2'h0, QUAL_MINUS, FMT_LSINGLE}, 6'h10);
      i_issue.set_ctrl(1'b1, 2'h2);
      flags('{4'h0, CLS_COMMON, 2'h0, QUAL_DYN, FMT_LDOUBLE}, 6'h10);
      flags('{4'h0, CLS_COMMON, 2'h0, QUAL_CHOP, FMT_LDOUBLE}, 6'h00);
      flags('{4'hA, CLS_MEMORY, 2'h0, QUAL_NONE, FMT_IDOUBLE}, 6'h0A);
      rd(`OFS_STATUS);
      check({32'h0, d}, 64'hEB0C);
      cls(FMT_ISINGLE, 64'h7F80_0000, 9'h004);
      cls(FMT_ISINGLE, 64'h7FC0_0000, 9'h002);
      cls(FMT_ISINGLE, 64'h7FA0_0000, 9'h001);
      cls(FMT_ISINGLE, 64'h8000_0001, 9'h108);
      cls(FMT_ISINGLE, 64'h8000_0000, 9'h140);
      cls(FMT_ISINGLE, 64'h0, 9'h0C0);
      cls(FMT_LSINGLE, 64'h1, 9'h020);
      cls(FMT_LSINGLE, 64'h8000_0000, 9'h110);
      cls(FMT_LSINGLE, 64'h7F80_0000, 9'h040);
      cls(FMT_IDOUBLE, 64'h7FF8_0000_0000_0000, 9'h002);
      cls(FMT_LDOUBLE, 64'h8000_0000_0000_0001, 9'h110);
      round(FMT_ISINGLE, QUAL_NONE, 2'h2, rc(0, 13'h80, 0, 0, 0), 53'hC0_0000, 64'h4040_0000, 2'h0);
      round(FMT_ISINGLE, QUAL_MINUS, 2'h2, rc(1, 13'h80, 0, 0, 0), 53'hC0_0000, 64'hC040_0000, 2'h0);
      round(FMT_ISINGLE, QUAL_NONE, 2'h2, rc(0, 13'h80, 1, 0, 0), 53'h80_0001, 64'h4000_0002, 2'h0);
      round(FMT_ISINGLE, QUAL_CHOP, 2'h2, rc(0, 13'h80, 1, 1, 0), 53'h80_0001, 64'h4000_0001, 2'h0);
      round(FMT_ISINGLE, QUAL_MINUS, 2'h2, rc(1, 13'h80, 0, 1, 0), 53'h80_0001, 64'hC000_0002, 2'h0);
      round(FMT_ISINGLE, QUAL_DYN, 2'h3, rc(0, 13'h80, 0, 1, 0), 53'h80_0001, 64'h4000_0002, 2'h0);
      round(FMT_ISINGLE, QUAL_DYN, 2'h0, rc(0, 13'h80, 1, 1, 0), 53'h80_0001, 64'h4000_0001, 2'h0);
      round(FMT_ISINGLE, QUAL_DYN, 2'h1, rc(1, 13'h80, 0, 1, 0), 53'h80_0001, 64'hC000_0002, 2'h0);
      round(FMT_ISINGLE, QUAL_NONE, 2'h2, rc(0, 13'hFE, 1, 0, 0), 53'hFF_FFFF, 64'h0, 2'h1);
      round(FMT_ISINGLE, QUAL_CHOP, 2'h2, rc(0, 13'hFE, 1, 1, 0), 53'hFF_FFFF, 64'h7F7F_FFFF, 2'h0);
      round(FMT_ISINGLE, QUAL_NONE, 2'h2, rc(0, 13'h0, 1, 0, 0), 53'hFF_FFFF, 64'h0080_0000, 2'h0);
      round(FMT_ISINGLE, QUAL_NONE, 2'h2, rc(0, 13'h0, 0, 0, 0), 53'h80_0000, 64'h0, 2'h2);
      round(FMT_LSINGLE, QUAL_NONE, 2'h2, rc(0, 13'h80, 1, 0, 0), 53'h80_0000, 64'h4000_0001, 2'h0);
      round(FMT_LSINGLE, QUAL_CHOP, 2'h2, rc(0, 13'h80, 1, 1, 0), 53'h80_0001, 64'h4000_0001, 2'h0);
      round(FMT_LSINGLE, QUAL_NONE, 2'h2, rc(1, 13'h80, 0, 0, 1), 53'h80_0000, 64'h0, 2'h0);
      round(FMT_IDOUBLE, QUAL_NONE, 2'h2, rc(0, 13'h400, 1, 0, 0), 53'h10_0000_0000_0001,
            64'h4000_0000_0000_0002, 2'h0);
      finish_test();
   end
endmodule
